// ===== rtl/cc2_ctrl_regs.sv
// Codec 2 control register bank behind an APB slave
`timescale 1ns/10ps
module cc2_ctrl_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire cc2_pkg::cc2_addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_overflow_in,
    output logic [3:0] rate_factor_m1,
    output logic analog_loopback,
    output logic digital_loopback,
    output logic codec2_power_down,
    output logic soft_reset_pulse,
    output logic line_output_select,
    output cc2_pkg::cc2_half_db_t adc_gain_half_db,
    output logic adc_mute,
    output cc2_pkg::cc2_half_db_t dac_gain_half_db,
    output logic dac_mute,
    output logic irq
);
    import cc2_pkg::*;

    cc2_byte_t rate_reg, rate_next;
    cc2_byte_t adc_reg, adc_next;
    cc2_byte_t dac_reg, dac_next;
    logic [CC2_IRQ_W-1:0] stat_reg, stat_next;
    logic [CC2_IRQ_W-1:0] mask_reg, mask_next;
    logic [CC2_IRQ_W-1:0] stat_set, stat_clr;
    logic ovf_meta_reg, ovf_sync_reg, ovf_prev_reg;
    logic swrst_reg, irq_reg, err_reg;
    logic [31:0] rdata_reg;
    logic adc_rsvd, dac_rsvd;

    // Bus decode
    wire setup = psel && !penable && clk_en;
    wire access = psel && penable && clk_en;
    wire hit_rate = (paddr == CC2_ADDR_RATE);
    wire hit_adc = (paddr == CC2_ADDR_ADC);
    wire hit_dac = (paddr == CC2_ADDR_DAC);
    wire hit_stat = (paddr == CC2_ADDR_STAT);
    wire hit_mask = (paddr == CC2_ADDR_MASK);
    wire mapped = hit_rate || hit_adc || hit_dac || hit_stat || hit_mask;
    wire wr = access && pwrite && pstrb[0] && mapped;
    wire cc2_byte_t wbyte = pwdata[7:0];
    wire cc2_code_t w_adc_code = wbyte[CC2_ADC_GAIN_MSB:CC2_ADC_GAIN_LSB];
    wire cc2_code_t w_dac_code = wbyte[CC2_DAC_GAIN_MSB:CC2_DAC_GAIN_LSB];
    wire swrst_req = wr && hit_rate && wbyte[CC2_SWRST_BIT];

    // Reserved gain code detection on write
    function automatic logic code_reserved(input cc2_code_t c);
        code_reserved = (c > CC2_GAIN_MAX) && (c != CC2_GAIN_MUTE);
    endfunction
    wire rsvd_write = (wr && hit_adc && code_reserved(w_adc_code))
        || (wr && hit_dac && code_reserved(w_dac_code));

    // Register next values; soft reset restores defaults
    always_comb begin
        rate_next = rate_reg;
        adc_next = adc_reg;
        dac_next = dac_reg;
        if (swrst_req) begin
            rate_next = CC2_RATE_RST;
            adc_next = CC2_ADC_RST;
            dac_next = CC2_DAC_RST;
        end else if (wr && hit_rate) begin
            rate_next = {wbyte[7:1], 1'b0};
        end else if (wr && hit_adc) begin
            adc_next = {1'b0, wbyte[6:0]};
        end else if (wr && hit_dac) begin
            dac_next = {2'h0, wbyte[5:0]};
        end
    end

    // Sticky status: a set in the clearing cycle wins
    always_comb begin
        stat_set = '0;
        stat_set[CC2_IRQ_OVF] = ovf_sync_reg && !ovf_prev_reg;
        stat_set[CC2_IRQ_RSVD] = rsvd_write;
        stat_set[CC2_IRQ_SWRST] = swrst_req;
        stat_clr = (wr && hit_stat) ? wbyte[CC2_IRQ_W-1:0] : '0;
        stat_next = (stat_reg & ~stat_clr) | stat_set;
        mask_next = (wr && hit_mask) ? wbyte[CC2_IRQ_W-1:0] : mask_reg;
    end

    // Read mux, overflow shows live in bit 7
    wire cc2_byte_t adc_view = {ovf_sync_reg, adc_reg[6:0]};
    wire cc2_byte_t rd_byte =
        hit_rate ? rate_reg :
        hit_adc ? adc_view :
        hit_dac ? dac_reg :
        hit_stat ? {5'h00, stat_reg} :
        hit_mask ? {5'h00, mask_reg} : 8'h00;

    // Overflow pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_meta_reg <= 1'b0;
            ovf_sync_reg <= 1'b0;
            ovf_prev_reg <= 1'b0;
        end else if (clk_en) begin
            ovf_meta_reg <= adc_overflow_in;
            ovf_sync_reg <= ovf_meta_reg;
            ovf_prev_reg <= ovf_sync_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_reg <= CC2_RATE_RST;
            adc_reg <= CC2_ADC_RST;
            dac_reg <= CC2_DAC_RST;
            stat_reg <= CC2_IRQ_RST;
            mask_reg <= CC2_IRQ_RST;
        end else if (clk_en) begin
            rate_reg <= rate_next;
            adc_reg <= adc_next;
            dac_reg <= dac_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swrst_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            swrst_reg <= swrst_req;
            irq_reg <= |(stat_next & mask_next);
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (setup) begin
            rdata_reg <= {24'h00_0000, rd_byte};
            err_reg <= !mapped;
        end
    end

    cc2_gain_decode u_adc_gain (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .code(adc_reg[CC2_ADC_GAIN_MSB:CC2_ADC_GAIN_LSB]),
        .gain_half_db(adc_gain_half_db),
        .mute(adc_mute),
        .reserved(adc_rsvd)
    );

    cc2_gain_decode u_dac_gain (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .code(dac_reg[CC2_DAC_GAIN_MSB:CC2_DAC_GAIN_LSB]),
        .gain_half_db(dac_gain_half_db),
        .mute(dac_mute),
        .reserved(dac_rsvd)
    );

    assign prdata = rdata_reg;
    assign pready = clk_en;
    assign pslverr = err_reg;
    assign rate_factor_m1 = rate_reg[CC2_RATE_MSB:CC2_RATE_LSB];
    assign analog_loopback = rate_reg[CC2_ALOOP_BIT];
    assign digital_loopback = rate_reg[CC2_DLOOP_BIT];
    assign codec2_power_down = rate_reg[CC2_PDN_BIT];
    assign soft_reset_pulse = swrst_reg;
    assign line_output_select = adc_reg[CC2_LINE_OUT_BIT];
    assign irq = irq_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire wr_rate_plain = wr && hit_rate && !wbyte[CC2_SWRST_BIT];
    wire wr_adc = wr && hit_adc && !swrst_req;
    wire wr_dac = wr && hit_dac;

    a_rate_field_lands: assert property (
        wr_rate_plain |=> rate_factor_m1 == $past(wbyte[7:4]))
        else $error("rate factor not stored");
    a_soft_rst_default: assert property (
        swrst_req |=> rate_reg == CC2_RATE_RST && soft_reset_pulse)
        else $error("soft reset did not restore default");
    a_aloop_follows: assert property (
        wr_rate_plain |=> analog_loopback == $past(wbyte[3]))
        else $error("analog loopback not following write");
    a_dloop_follows: assert property (
        wr_rate_plain |=> digital_loopback == $past(wbyte[2]))
        else $error("digital loopback not following write");
    a_pdn_follows: assert property (
        wr_rate_plain |=> codec2_power_down == $past(wbyte[1]))
        else $error("power down not following write");
    a_swrst_once: assert property (
        swrst_req ##1 clk_en && !swrst_req |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    a_ovf_readback: assert property (
        setup && hit_adc |=> prdata[CC2_OVF_BIT] == $past(ovf_sync_reg))
        else $error("overflow bit not read back");
    a_adc_mute_path: assert property (
        wr_adc && w_adc_code == CC2_GAIN_MUTE ##1 clk_en |=> adc_mute)
        else $error("ADC mute code not muting");
    a_line_out_sel: assert property (
        wr_adc |=> line_output_select == $past(wbyte[0]))
        else $error("line output select not stored");
    a_dac_top_ignored: assert property (
        setup && hit_dac |=> prdata[7:6] == 2'h0)
        else $error("DAC unused bits not ignored");
    a_rsvd_flagged: assert property (
        rsvd_write && !swrst_req |=> stat_reg[CC2_IRQ_RSVD])
        else $error("reserved gain code not flagged");
    a_irq_level: assert property (
        clk_en |=> irq == |($past(stat_next) & $past(mask_next)))
        else $error("interrupt level wrong");

    // Bus reads, errors and strobes
    a_unmapped_err: assert property (
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        setup && mapped |=> !pslverr)
        else $error("error flagged on mapped access");
    a_rdata_stands: assert property (
        !setup |=> $stable(prdata) && $stable(pslverr))
        else $error("read data changed outside setup");
    a_rate_readback: assert property (
        setup && hit_rate |=> prdata[7:0] == $past(rate_reg))
        else $error("rate register read back wrong");
    a_adc_readback: assert property (
        setup && hit_adc |=> prdata[6:0] == $past(adc_reg[6:0]))
        else $error("ADC register read back wrong");
    a_dac_readback: assert property (
        setup && hit_dac |=> prdata[5:0] == $past(dac_reg[5:0]))
        else $error("DAC register read back wrong");
    a_strobe_ignored: assert property (
        access && pwrite && !pstrb[0]
        |=> $stable(rate_reg) && $stable(adc_reg) && $stable(dac_reg))
        else $error("write acted without byte strobe");

    // Register 7 and software reset
    a_swrst_bit_low: assert property (
        wr && hit_rate |=> !rate_reg[CC2_SWRST_BIT])
        else $error("soft reset bit stored");
    a_swrst_gains: assert property (
        swrst_req |=> adc_reg == CC2_ADC_RST && dac_reg == CC2_DAC_RST)
        else $error("soft reset left gain registers");
    a_swrst_flag: assert property (
        swrst_req |=> stat_reg[CC2_IRQ_SWRST])
        else $error("soft reset status not set");
    a_pulse_only_req: assert property (
        clk_en && !swrst_req |=> !soft_reset_pulse)
        else $error("soft reset pulse without request");

    // Register 8 and 9 fields
    a_ovf_not_stored: assert property (
        wr_adc |=> !adc_reg[CC2_OVF_BIT])
        else $error("overflow bit written by software");
    a_dac_top_zero: assert property (
        wr_dac |=> dac_reg[7:6] == 2'h0)
        else $error("DAC unused bits stored");
    a_dac_code_lands: assert property (
        wr_dac |=> dac_reg[5:0] == $past(w_dac_code))
        else $error("DAC gain code not stored");
    a_adc_code_lands: assert property (
        wr_adc |=> adc_reg[6:1] == $past(w_adc_code))
        else $error("ADC gain code not stored");

    // Gain stages, one cycle behind the registers
    a_adc_bottom: assert property (
        wr_adc && w_adc_code == CC2_GAIN_MIN ##1 clk_en
        |=> adc_gain_half_db == CC2_GAIN_BASE && !adc_mute)
        else $error("ADC lowest gain wrong");
    a_adc_top: assert property (
        wr_adc && w_adc_code == CC2_GAIN_MAX ##1 clk_en
        |=> adc_gain_half_db == CC2_GAIN_TOP && !adc_mute)
        else $error("ADC highest gain wrong");
    a_adc_zero: assert property (
        wr_adc && w_adc_code == CC2_GAIN_ZERO ##1 clk_en
        |=> adc_gain_half_db == 8'sh00 && !adc_mute)
        else $error("ADC zero code not unity");
    a_dac_bottom: assert property (
        wr_dac && w_dac_code == CC2_GAIN_MIN ##1 clk_en
        |=> dac_gain_half_db == CC2_GAIN_BASE && !dac_mute)
        else $error("DAC lowest gain wrong");
    a_dac_zero: assert property (
        wr_dac && w_dac_code == CC2_GAIN_ZERO ##1 clk_en
        |=> dac_gain_half_db == 8'sh00 && !dac_mute)
        else $error("DAC zero code not unity");
    a_dac_mute_path: assert property (
        wr_dac && w_dac_code == CC2_GAIN_MUTE ##1 clk_en
        |=> dac_mute)
        else $error("DAC mute code not muting");
    a_adc_rsvd_mute: assert property (
        wr_adc && code_reserved(w_adc_code) ##1 clk_en
        |=> adc_rsvd && adc_mute)
        else $error("ADC reserved code not muted");
    a_dac_rsvd_mute: assert property (
        wr_dac && code_reserved(w_dac_code) ##1 clk_en
        |=> dac_rsvd && dac_mute)
        else $error("DAC reserved code not muted");

    // Status, mask and interrupt
    a_ovf_edge_sets: assert property (
        clk_en && ovf_sync_reg && !ovf_prev_reg
        |=> stat_reg[CC2_IRQ_OVF])
        else $error("overflow edge not latched");
    a_ovf_sync_delay: assert property (
        clk_en |=> ovf_sync_reg == $past(ovf_meta_reg))
        else $error("overflow synchroniser skipped a stage");
    a_stat_w1c: assert property (
        wr && hit_stat && wbyte[CC2_IRQ_OVF] && !stat_set[CC2_IRQ_OVF]
        |=> !stat_reg[CC2_IRQ_OVF])
        else $error("status bit not cleared by one");
    a_set_wins: assert property (
        wr && hit_stat && wbyte[CC2_IRQ_OVF] && stat_set[CC2_IRQ_OVF]
        |=> stat_reg[CC2_IRQ_OVF])
        else $error("clear beat a new event");
    a_mask_stored: assert property (
        wr && hit_mask |=> mask_reg == $past(wbyte[CC2_IRQ_W-1:0]))
        else $error("mask not stored");
    a_irq_masked_off: assert property (
        clk_en && mask_next == 3'h0 |=> !irq)
        else $error("interrupt raised while all masked");
    a_freeze: assert property (
        !clk_en
        |=> $stable(rate_reg) && $stable(stat_reg) && $stable(irq))
        else $error("state moved with clock enable low");

    c_soft_reset: cover property (swrst_req ##1 soft_reset_pulse);
    c_adc_muted: cover property (wr_adc ##2 adc_mute);
    c_irq_raised: cover property (!irq ##1 irq);
    c_dac_loud: cover property (dac_gain_half_db == CC2_GAIN_TOP);
endmodule

// ===== rtl/cc2_gain_decode.sv
// Gain code decoder for one programmable gain stage
`timescale 1ns/10ps
module cc2_gain_decode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire cc2_pkg::cc2_code_t code,
    output cc2_pkg::cc2_half_db_t gain_half_db,
    output logic mute,
    output logic reserved
);
    import cc2_pkg::*;

    cc2_half_db_t gain_reg, steps, lin_gain;
    logic mute_reg, rsvd_reg;
    wire is_zero = (code == CC2_GAIN_ZERO);
    wire is_mute = (code == CC2_GAIN_MUTE);
    wire is_lin = !is_zero && (code <= CC2_GAIN_MAX);
    wire is_rsvd = !is_zero && !is_lin && !is_mute;

    assign steps = $signed({2'h0, code}) - 8'sh01;
    assign lin_gain = CC2_GAIN_BASE + steps * CC2_GAIN_STEP;
    // Reserved codes fail safe to mute
    wire cc2_half_db_t gain_next = is_lin ? lin_gain : 8'sh00;
    wire mute_next = is_mute || is_rsvd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_reg <= 8'sh00;
            mute_reg <= 1'b0;
            rsvd_reg <= 1'b0;
        end else if (clk_en) begin
            gain_reg <= gain_next;
            mute_reg <= mute_next;
            rsvd_reg <= is_rsvd;
        end
    end

    assign gain_half_db = gain_reg;
    assign mute = mute_reg;
    assign reserved = rsvd_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_gain_bottom_step: assert property (
        $past(clk_en) && $past(code) == CC2_GAIN_MIN
        |-> gain_half_db == CC2_GAIN_BASE && !mute)
        else $error("gain for lowest linear code wrong");
    a_gain_top_step: assert property (
        $past(clk_en) && $past(code) == CC2_GAIN_MAX
        |-> gain_half_db == CC2_GAIN_TOP && !mute)
        else $error("gain for highest linear code wrong");
    a_zero_is_unity: assert property (
        $past(clk_en) && $past(code) == CC2_GAIN_ZERO
        |-> gain_half_db == 8'sh00 && !mute)
        else $error("zero code not unity gain");
    a_unity_code: assert property (
        $past(clk_en) && $past(code) == CC2_GAIN_UNITY
        |-> gain_half_db == 8'sh00)
        else $error("unity code not 0 dB");
endmodule

// ===== shared/cc2_pkg.sv
// Constants and types for the codec 2 control register bank
package cc2_pkg;
    typedef logic [11:0] cc2_addr_t;
    typedef logic [7:0] cc2_byte_t;
    typedef logic [5:0] cc2_code_t;
    typedef logic signed [7:0] cc2_half_db_t;

    // Register indices; byte address is four times the index
    localparam cc2_byte_t CC2_IDX_RATE = 8'h07;
    localparam cc2_byte_t CC2_IDX_ADC = 8'h08;
    localparam cc2_byte_t CC2_IDX_DAC = 8'h09;
    localparam cc2_byte_t CC2_IDX_IRQ_STAT = 8'h10;
    localparam cc2_byte_t CC2_IDX_IRQ_MASK = 8'h11;
    localparam cc2_addr_t CC2_ADDR_RATE = {2'h0, CC2_IDX_RATE, 2'h0};
    localparam cc2_addr_t CC2_ADDR_ADC = {2'h0, CC2_IDX_ADC, 2'h0};
    localparam cc2_addr_t CC2_ADDR_DAC = {2'h0, CC2_IDX_DAC, 2'h0};
    localparam cc2_addr_t CC2_ADDR_STAT = {2'h0, CC2_IDX_IRQ_STAT, 2'h0};
    localparam cc2_addr_t CC2_ADDR_MASK = {2'h0, CC2_IDX_IRQ_MASK, 2'h0};

    // Values after reset
    localparam cc2_byte_t CC2_RATE_RST = 8'h50;
    localparam cc2_byte_t CC2_ADC_RST = 8'h00;
    localparam cc2_byte_t CC2_DAC_RST = 8'h00;
    localparam logic [2:0] CC2_IRQ_RST = 3'h0;

    // Field positions
    localparam int CC2_RATE_MSB = 7;
    localparam int CC2_RATE_LSB = 4;
    localparam int CC2_ALOOP_BIT = 3;
    localparam int CC2_DLOOP_BIT = 2;
    localparam int CC2_PDN_BIT = 1;
    localparam int CC2_SWRST_BIT = 0;
    localparam int CC2_OVF_BIT = 7;
    localparam int CC2_ADC_GAIN_MSB = 6;
    localparam int CC2_ADC_GAIN_LSB = 1;
    localparam int CC2_LINE_OUT_BIT = 0;
    localparam int CC2_DAC_GAIN_MSB = 5;
    localparam int CC2_DAC_GAIN_LSB = 0;

    // Interrupt status bits
    localparam int CC2_IRQ_W = 3;
    localparam int CC2_IRQ_OVF = 0;
    localparam int CC2_IRQ_RSVD = 1;
    localparam int CC2_IRQ_SWRST = 2;

    // Gain code map, gain in half-dB units
    localparam cc2_code_t CC2_GAIN_ZERO = 6'h00;
    localparam cc2_code_t CC2_GAIN_MIN = 6'h01;
    localparam cc2_code_t CC2_GAIN_MAX = 6'h21;
    localparam cc2_code_t CC2_GAIN_UNITY = 6'h19;
    localparam cc2_code_t CC2_GAIN_MUTE = 6'h30;
    localparam cc2_half_db_t CC2_GAIN_BASE = 8'shb8;
    localparam cc2_half_db_t CC2_GAIN_STEP = 8'sh03;
    localparam cc2_half_db_t CC2_GAIN_TOP = 8'sh18;
endpackage

// ===== verif/cc2_ctrl_regs_tb.sv
// Self-checking testbench for the codec 2 control register bank
`timescale 1ns/10ps
module cc2_ctrl_regs_tb;
    import cc2_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    cc2_addr_t paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic adc_overflow_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] rate_factor_m1;
    logic analog_loopback;
    logic digital_loopback;
    logic codec2_power_down;
    logic soft_reset_pulse;
    logic line_output_select;
    cc2_half_db_t adc_gain_half_db;
    logic adc_mute;
    cc2_half_db_t dac_gain_half_db;
    logic dac_mute;
    logic irq;
    int error_cnt = 0;
    int comparisons = 0;
    int pulse_cnt = 0;
    logic [31:0] r;
    logic e;
    logic m;
    logic [5:0] c;
    logic [7:0] v;
    int p0;
    logic [7:0] rate_vals [4] = '{8'hae, 8'h34, 8'h0a, 8'hf0};
    logic [5:0] codes [10] = '{6'h00, 6'h01, 6'h02, 6'h18, 6'h19, 6'h1a,
        6'h20, 6'h21, 6'h22, 6'h30};

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        if (soft_reset_pulse === 1'b1) begin
            pulse_cnt++;
        end
    end

    cc2_ctrl_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_overflow_in(adc_overflow_in),
        .rate_factor_m1(rate_factor_m1), .analog_loopback(analog_loopback),
        .digital_loopback(digital_loopback),
        .codec2_power_down(codec2_power_down),
        .soft_reset_pulse(soft_reset_pulse),
        .line_output_select(line_output_select),
        .adc_gain_half_db(adc_gain_half_db), .adc_mute(adc_mute),
        .dac_gain_half_db(dac_gain_half_db), .dac_mute(dac_mute), .irq(irq));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task xfer(input logic wr, input cc2_addr_t a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input cc2_addr_t a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf, r, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task rdchk(input cc2_addr_t a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    // Lets register and gain outputs land before sampling
    task settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    function automatic logic [7:0] gexp(input logic [5:0] code);
        int g;
        g = (code >= 6'h01 && code <= 6'h21) ? -72 + 3 * (int'(code) - 1) : 0;
        return g[7:0];
    endfunction

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({28'h0, rate_factor_m1}, 32'h5);
        chk({29'h0, analog_loopback, digital_loopback, codec2_power_down},
            32'h0);
        rdchk(CC2_ADDR_RATE, 32'h50);
        rdchk(CC2_ADDR_ADC, {24'h0, CC2_ADC_RST});
        rdchk(CC2_ADDR_DAC, {24'h0, CC2_DAC_RST});
        foreach (rate_vals[i]) begin
            v = rate_vals[i];
            wr(CC2_ADDR_RATE, {24'h0, v});
            settle;
            chk({28'h0, rate_factor_m1}, {28'h0, v[7:4]});
            chk({31'h0, analog_loopback}, {31'h0, v[3]});
            chk({31'h0, digital_loopback}, {31'h0, v[2]});
            chk({31'h0, codec2_power_down}, {31'h0, v[1]});
            rdchk(CC2_ADDR_RATE, {24'h0, v});
        end
        chk(pulse_cnt, 0);
        // Unmapped place and masked byte lane
        xfer(1'b1, 12'h3f0, 32'hff, 4'hf, r, e);
        chk({31'h0, e}, 32'h1);
        xfer(1'b0, 12'h3f0, 32'h0, 4'h0, r, e);
        chk({r[31:1], e}, 32'h1);
        xfer(1'b1, CC2_ADDR_DAC, 32'h15, 4'he, r, e);
        rdchk(CC2_ADDR_DAC, 32'h0);
        // Wait states while the clock enable is low
        fork
            xfer(1'b0, CC2_ADDR_RATE, 32'h0, 4'h0, r, e);
            begin
                repeat (2) @(posedge pclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        chk(r, 32'hf0);
        // Overflow flag, sticky status and interrupt masking
        wr(CC2_ADDR_MASK, 32'h1);
        adc_overflow_in <= 1'b1;
        settle;
        settle;
        chk({31'h0, irq}, 32'h1);
        rdchk(CC2_ADDR_ADC, 32'h80);
        rdchk(CC2_ADDR_STAT, 32'h1);
        wr(CC2_ADDR_STAT, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        adc_overflow_in <= 1'b0;
        settle;
        settle;
        rdchk(CC2_ADDR_ADC, 32'h0);
        wr(CC2_ADDR_MASK, 32'h0);
        adc_overflow_in <= 1'b1;
        settle;
        settle;
        chk({31'h0, irq}, 32'h0);
        wr(CC2_ADDR_MASK, 32'h1);
        settle;
        chk({31'h0, irq}, 32'h1);
        wr(CC2_ADDR_STAT, 32'h1);
        adc_overflow_in <= 1'b0;
        // Gain codes on both stages, reserved and mute included
        foreach (codes[i]) begin
            c = codes[i];
            m = (c == 6'h30) || (c > 6'h21);
            wr(CC2_ADDR_ADC, {24'h0, 1'b0, c, i[0]});
            wr(CC2_ADDR_DAC, {24'h0, 2'b11, c});
            settle;
            chk({31'h0, line_output_select}, {31'h0, i[0]});
            chk({30'h0, adc_mute, dac_mute}, {30'h0, m, m});
            if (!m) begin
                chk({24'h0, adc_gain_half_db}, {24'h0, gexp(c)});
                chk({24'h0, dac_gain_half_db}, {24'h0, gexp(c)});
            end
            rdchk(CC2_ADDR_ADC, {24'h0, 1'b0, c, i[0]});
            rdchk(CC2_ADDR_DAC, {26'h0, c});
        end
        rdchk(CC2_ADDR_STAT, 32'h2);
        // Software reset restores defaults
        p0 = pulse_cnt;
        wr(CC2_ADDR_RATE, 32'hf1);
        settle;
        chk(pulse_cnt, p0 + 1);
        chk({28'h0, rate_factor_m1}, 32'h5);
        rdchk(CC2_ADDR_RATE, 32'h50);
        rdchk(CC2_ADDR_ADC, 32'h0);
        rdchk(CC2_ADDR_STAT, 32'h6);
        close_out;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(40 * 20000);
        error_cnt++;
        close_out;
    end
endmodule
